// [nio_map.vh]
// register map and field constants for the nibble port block
// assumes a 32-bit axi4-lite slave with one register per aligned word
`ifndef NIO_MAP_VH
`define NIO_MAP_VH
`define NIO_OFS_PORT_A 8'h00
`define NIO_OFS_PORT_B 8'h04
`define NIO_OFS_PORT_C 8'h08
`define NIO_OFS_PORT_D 8'h0c
`define NIO_OFS_PORT_E 8'h10
`define NIO_OFS_PORT_F 8'h14
`define NIO_OFS_PORT_G 8'h18
`define NIO_OFS_PORT_H 8'h1c
`define NIO_OFS_PORT_I 8'h20
`define NIO_OFS_PORT_J 8'h24
`define NIO_OFS_PORT_K 8'h28
`define NIO_OFS_PORT_L 8'h2c
`define NIO_OFS_AB_DIR 8'h30
`define NIO_OFS_STANDBY 8'h34
`define NIO_DIR_A_BIT 0
`define NIO_DIR_B_BIT 1
`define NIO_H_FLAG_BIT 2
`define NIO_AB_DIR_RST 4'h0
`define NIO_SETTLE_CYCLES 3'h5
`define NIO_RESP_OKAY 2'b00
`define NIO_RESP_SLVERR 2'b10
`endif

// [nio_pins_model.sv]
// pin-side model: outside circuit levels on every port pin
// assumes the bench sets the outside levels; a/b pins follow the block while it drives
`timescale 1ns/1ps
module nio_pins_model (
	// outside levels
	input wire [34:0] ext,
	// block drive on two-way pins
	input wire [3:0] port_a_out,
	input wire [3:0] port_a_oe_n,
	input wire [3:0] port_b_out,
	input wire [3:0] port_b_oe_n,
	// levels seen by the block
	output wire [3:0] port_a_in,
	output wire [3:0] port_b_in,
	output wire [1:0] port_c_in,
	output wire [3:0] port_d_in,
	output wire [3:0] port_e_in,
	output wire [2:0] port_f_in,
	output wire [1:0] port_g_in,
	output wire [1:0] port_h_in,
	output wire [3:0] port_i_in,
	output wire [1:0] port_j_in,
	output wire [1:0] port_k_in,
	output wire [1:0] port_l_in
);
	// a driven pin wins; contention with the outside is not modelled
	assign port_a_in = (port_a_out & ~port_a_oe_n) | (ext[3:0] & port_a_oe_n);
	assign port_b_in = (port_b_out & ~port_b_oe_n) | (ext[7:4] & port_b_oe_n);
	assign port_c_in = ext[9:8];
	assign port_d_in = ext[13:10];
	assign port_e_in = ext[17:14];
	assign port_f_in = ext[20:18];
	assign port_g_in = ext[22:21];
	assign port_h_in = ext[24:23];
	assign port_i_in = ext[28:25];
	assign port_j_in = ext[30:29];
	assign port_k_in = ext[32:31];
	assign port_l_in = ext[34:33];
endmodule // nio_pins_model

// [nio_ports.v]
// nibble-wide parallel port block: ports a..l, a/b direction register,
// standby wake on port h bit 0 and sticky edge flag on port h bit 1.
// assumes an axi4-lite master on aclk; pins come from outside and are synchronised.
//
// Behaviour
// - port h two bits, build-time direction
// - rising wake pin edge leaves standby
// - edge on edge pin sets h bit2
// - edge flag also sets during standby
// - any port h write clears flag
// - edge polarity is a build parameter
// - port i reads four pin levels
// - port j reads two pin levels
// - port k reads two pin levels
// - l bit0 output, bit1 build direction
// - l bit0 reads back driven state
// - dir bit0 sets port a direction
// - dir bit1 sets port b direction
// - direction register resets to zero
// - port b pin n to bit n
// - i j k input only, l0 output
// - port g absent in small package
// - a/b data access ignores direction; reads here return the latch when output, the pin when input
// - ports c..f build-time direction
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "nio_map.vh"

module nio_ports #(
	parameter [1:0] C_DIR = 2'b00, // 1 = output, per bit
	parameter [3:0] D_DIR = 4'h0,
	parameter [3:0] E_DIR = 4'h0,
	parameter [2:0] F_DIR = 3'h0,
	parameter [1:0] G_DIR = 2'b00,
	parameter [1:0] H_DIR = 2'b00,
	parameter HAS_PORT_G = 1,
	parameter H1_RISING = 1,
	parameter I_ANALOG = 0,
	parameter J_ALT = 0,
	parameter K_ALT = 0,
	parameter L1_OUT = 0
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// standby
	output reg standby_q,
	// pin inputs
	input wire [3:0] port_a_in,
	input wire [3:0] port_b_in,
	input wire [1:0] port_c_in,
	input wire [3:0] port_d_in,
	input wire [3:0] port_e_in,
	input wire [2:0] port_f_in,
	input wire [1:0] port_g_in,
	input wire [1:0] port_h_in,
	input wire [3:0] port_i_in,
	input wire [1:0] port_j_in,
	input wire [1:0] port_k_in,
	input wire [1:0] port_l_in,
	// pin outputs and enables (enable low = driving)
	output reg [3:0] port_a_out,
	output reg [3:0] port_a_oe_n,
	output reg [3:0] port_b_out,
	output reg [3:0] port_b_oe_n,
	output reg [1:0] port_c_out,
	output reg [1:0] port_c_oe_n,
	output reg [3:0] port_d_out,
	output reg [3:0] port_d_oe_n,
	output reg [3:0] port_e_out,
	output reg [3:0] port_e_oe_n,
	output reg [2:0] port_f_out,
	output reg [2:0] port_f_oe_n,
	output reg [1:0] port_g_out,
	output reg [1:0] port_g_oe_n,
	output reg [1:0] port_h_out,
	output reg [1:0] port_h_oe_n,
	output reg [1:0] port_l_out,
	output reg [1:0] port_l_oe_n
);

	localparam NPIN = 35;
	localparam [1:0] G_EN = (HAS_PORT_G != 0) ? 2'b11 : 2'b00;
	localparam [1:0] L_DIR = {(L1_OUT != 0), 1'b1};

	// three-stage synchronisers; stage 1 feeds only stage 2
	wire [NPIN-1:0] pin_raw;
	reg [NPIN-1:0] s1_q;
	reg [NPIN-1:0] s2_q;
	reg [NPIN-1:0] s3_q;
	reg [NPIN-1:0] pin_q;
	assign pin_raw = {port_l_in, port_k_in, port_j_in, port_i_in, port_h_in, port_g_in,
		port_f_in, port_e_in, port_d_in, port_c_in, port_b_in, port_a_in};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			always @(posedge aclk) begin
				if (!aresetn) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					// a change counts once stages two and three agree
					if (s2_q[gi] == s3_q[gi])
						pin_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	wire [3:0] a_pin = pin_q[3:0];
	wire [3:0] b_pin = pin_q[7:4];
	wire [1:0] c_pin = pin_q[9:8];
	wire [3:0] d_pin = pin_q[13:10];
	wire [3:0] e_pin = pin_q[17:14];
	wire [2:0] f_pin = pin_q[20:18];
	wire [1:0] g_pin = pin_q[22:21];
	wire [1:0] h_pin = pin_q[24:23];
	wire [3:0] i_pin = pin_q[28:25];
	wire [1:0] j_pin = pin_q[30:29];
	wire [1:0] k_pin = pin_q[32:31];
	// l bit0 is output only, so its synchronised pin level is never read
	wire l1_pin = pin_q[34];

	// mixes stored output bits with live input bits by direction mask
	function [3:0] mix;
		input [3:0] dir;
		input [3:0] outv;
		input [3:0] inv;
		begin
			mix = (dir & outv) | (~dir & inv);
		end
	endfunction

	// data registers
	reg [3:0] a_q, b_q, d_q, e_q;
	reg [1:0] c_q, g_q, h_q, l_q;
	reg [2:0] f_q;
	reg [3:0] ab_dir_q;
	reg h_flag_q;
	reg h1_prev_q;
	reg h0_prev_q;

	// write channel: address and data taken in either order
	reg aw_got_q, w_got_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	wire do_write = aw_got_q && w_got_q && !s_axi_bvalid;
	wire wr_lane0 = w_strb_q[0];
	wire [3:0] wd = w_data_q[3:0];

	reg wr_ok;
	always @* begin
		case (aw_addr_q)
			`NIO_OFS_PORT_A, `NIO_OFS_PORT_B, `NIO_OFS_PORT_C, `NIO_OFS_PORT_D,
			`NIO_OFS_PORT_E, `NIO_OFS_PORT_F, `NIO_OFS_PORT_H, `NIO_OFS_PORT_I,
			`NIO_OFS_PORT_J, `NIO_OFS_PORT_K, `NIO_OFS_PORT_L, `NIO_OFS_AB_DIR,
			`NIO_OFS_STANDBY: wr_ok = 1'b1;
			`NIO_OFS_PORT_G: wr_ok = (HAS_PORT_G != 0);
			default: wr_ok = 1'b0;
		endcase
	end

	// edge detectors stay blind until the filter holds real pin levels,
	// so a pin already high at reset release is not taken for an edge
	reg [2:0] settle_q;
	wire armed = (settle_q == `NIO_SETTLE_CYCLES);
	always @(posedge aclk) begin
		if (!aresetn) begin
			settle_q <= 3'h0;
		end else if (!armed) begin
			settle_q <= settle_q + 3'h1;
		end
	end

	wire h_write = do_write && aw_addr_q == `NIO_OFS_PORT_H;
	wire h1_in = ~H_DIR[1];
	wire h1_rise = h_pin[1] & ~h1_prev_q;
	wire h1_fall = ~h_pin[1] & h1_prev_q;
	wire h1_edge = armed & ((H1_RISING != 0) ? h1_rise : h1_fall);
	wire h0_rise = armed & h_pin[0] & ~h0_prev_q & ~H_DIR[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `NIO_RESP_OKAY;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			a_q <= 4'h0;
			b_q <= 4'h0;
			c_q <= 2'h0;
			d_q <= 4'h0;
			e_q <= 4'h0;
			f_q <= 3'h0;
			g_q <= 2'h0;
			h_q <= 2'h0;
			l_q <= 2'h0;
			ab_dir_q <= `NIO_AB_DIR_RST;
			h_flag_q <= 1'b0;
			h1_prev_q <= 1'b0;
			h0_prev_q <= 1'b0;
			standby_q <= 1'b0;
		end else begin
			h1_prev_q <= h_pin[1];
			h0_prev_q <= h_pin[0];
			s_axi_awready <= !aw_got_q && s_axi_awvalid && !s_axi_awready;
			s_axi_wready <= !w_got_q && s_axi_wvalid && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `NIO_RESP_OKAY : `NIO_RESP_SLVERR;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				if (wr_lane0) begin
					case (aw_addr_q)
						`NIO_OFS_PORT_A: a_q <= wd;
						`NIO_OFS_PORT_B: b_q <= wd;
						`NIO_OFS_PORT_C: c_q <= wd[1:0];
						`NIO_OFS_PORT_D: d_q <= wd;
						`NIO_OFS_PORT_E: e_q <= wd;
						`NIO_OFS_PORT_F: f_q <= wd[2:0];
						`NIO_OFS_PORT_G: g_q <= wd[1:0] & G_EN;
						`NIO_OFS_PORT_H: h_q <= wd[1:0];
						`NIO_OFS_PORT_L: l_q <= wd[1:0];
						`NIO_OFS_AB_DIR: ab_dir_q <= wd;
						`NIO_OFS_STANDBY: standby_q <= wd[0];
						default: ;
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// flag: any port h write clears, a same-cycle edge wins
			if (h1_in && h1_edge)
				h_flag_q <= 1'b1;
			else if (h_write)
				h_flag_q <= 1'b0;
			// in standby, a wake edge beats a same-cycle standby write
			if (standby_q && h0_rise)
				standby_q <= 1'b0;
		end
	end

	// read channel
	reg [3:0] rd_val;
	reg rd_ok;
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`NIO_OFS_PORT_A: rd_val = ab_dir_q[`NIO_DIR_A_BIT] ? a_q : a_pin;
			`NIO_OFS_PORT_B: rd_val = ab_dir_q[`NIO_DIR_B_BIT] ? b_q : b_pin;
			`NIO_OFS_PORT_C: rd_val = mix({2'b00, C_DIR}, {2'b00, c_q}, {2'b00, c_pin});
			`NIO_OFS_PORT_D: rd_val = mix(D_DIR, d_q, d_pin);
			`NIO_OFS_PORT_E: rd_val = mix(E_DIR, e_q, e_pin);
			`NIO_OFS_PORT_F: rd_val = mix({1'b0, F_DIR}, {1'b0, f_q}, {1'b0, f_pin});
			`NIO_OFS_PORT_G: begin
				rd_val = mix({2'b00, G_DIR}, {2'b00, g_q}, {2'b00, g_pin}) & {2'b00, G_EN};
				rd_ok = (HAS_PORT_G != 0);
			end
			`NIO_OFS_PORT_H: rd_val = {1'b0, h_flag_q, 2'b00}
				| mix({2'b00, H_DIR}, {2'b00, h_q}, {2'b00, h_pin});
			`NIO_OFS_PORT_I: rd_val = (I_ANALOG != 0) ? 4'h0 : i_pin;
			`NIO_OFS_PORT_J: rd_val = (J_ALT != 0) ? 4'h0 : {2'b00, j_pin};
			`NIO_OFS_PORT_K: rd_val = (K_ALT != 0) ? 4'h0 : {2'b00, k_pin};
			`NIO_OFS_PORT_L: rd_val = {2'b00, (L1_OUT != 0) ? l_q[1] : l1_pin, l_q[0]};
			`NIO_OFS_AB_DIR: rd_val = ab_dir_q;
			`NIO_OFS_STANDBY: rd_val = {3'b000, standby_q};
			default: begin
				rd_val = 4'h0;
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `NIO_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {28'h0000000, rd_val};
				s_axi_rresp <= rd_ok ? `NIO_RESP_OKAY : `NIO_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// pin drive; undriven pins have enable high
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_a_out <= 4'h0;
			port_a_oe_n <= 4'hf;
			port_b_out <= 4'h0;
			port_b_oe_n <= 4'hf;
			port_c_out <= 2'h0;
			port_c_oe_n <= 2'h3;
			port_d_out <= 4'h0;
			port_d_oe_n <= 4'hf;
			port_e_out <= 4'h0;
			port_e_oe_n <= 4'hf;
			port_f_out <= 3'h0;
			port_f_oe_n <= 3'h7;
			port_g_out <= 2'h0;
			port_g_oe_n <= 2'h3;
			port_h_out <= 2'h0;
			port_h_oe_n <= 2'h3;
			port_l_out <= 2'h0;
			port_l_oe_n <= 2'h3;
		end else begin
			port_a_out <= a_q;
			port_a_oe_n <= {4{~ab_dir_q[`NIO_DIR_A_BIT]}};
			port_b_out <= b_q;
			port_b_oe_n <= {4{~ab_dir_q[`NIO_DIR_B_BIT]}};
			port_c_out <= c_q;
			port_c_oe_n <= ~C_DIR;
			port_d_out <= d_q;
			port_d_oe_n <= ~D_DIR;
			port_e_out <= e_q;
			port_e_oe_n <= ~E_DIR;
			port_f_out <= f_q;
			port_f_oe_n <= ~F_DIR;
			port_g_out <= g_q;
			port_g_oe_n <= ~(G_DIR & G_EN);
			port_h_out <= h_q;
			port_h_oe_n <= ~H_DIR;
			port_l_out <= l_q;
			port_l_oe_n <= ~L_DIR;
		end
	end

endmodule // nio_ports

// [nio_ports_assertions.sv]
// checker for nio_ports: pin enables, read data and standby wake
// assumes it is bound to nio_ports and sees only its ports
`timescale 1ns/1ps
`include "nio_map.vh"
module nio_ports_assertions #(
	parameter [1:0] H_DIR = 2'b00
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// read address and data
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	// standby and pins
	input wire standby_q,
	input wire [1:0] port_h_in,
	input wire [3:0] port_a_out,
	input wire [3:0] port_a_oe_n,
	input wire [3:0] port_b_oe_n,
	input wire [1:0] port_h_oe_n,
	input wire [1:0] port_l_out,
	input wire [1:0] port_l_oe_n
);
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_dir_reset;
		$rose(aresetn) |-> ##1 port_a_oe_n == 4'hf && port_b_oe_n == 4'hf;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("a/b not inputs after reset");
	property p_a_group;
		port_a_oe_n == 4'h0 || port_a_oe_n == 4'hf;
	endproperty
	a_a_group: assert property (p_a_group) else $error("port a bits split direction");
	property p_b_group;
		port_b_oe_n == 4'h0 || port_b_oe_n == 4'hf;
	endproperty
	a_b_group: assert property (p_b_group) else $error("port b bits split direction");
	property p_l0_out;
		$past(aresetn) |-> port_l_oe_n[0] == 1'b0;
	endproperty
	a_l0_out: assert property (p_l0_out) else $error("port l bit0 not driving");
	property p_h_dir;
		$past(aresetn) |-> port_h_oe_n == ~H_DIR;
	endproperty
	a_h_dir: assert property (p_h_dir) else $error("port h direction wrong");
	// the pin filter adds a few cycles, so the wake gets a window
	property p_wake;
		!H_DIR[0] && standby_q && $rose(port_h_in[0]) |-> ##[1:8] !standby_q;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on rising pin");
	property p_l_mon;
		ar_hs && s_axi_araddr == `NIO_OFS_PORT_L |=> s_axi_rdata[0] == port_l_out[0];
	endproperty
	a_l_mon: assert property (p_l_mon) else $error("port l bit0 readback wrong");
	property p_a_back;
		ar_hs && s_axi_araddr == `NIO_OFS_PORT_A && port_a_oe_n == 4'h0
			|=> s_axi_rdata[3:0] == port_a_out;
	endproperty
	a_a_back: assert property (p_a_back) else $error("port a output readback wrong");
endmodule // nio_ports_assertions

bind nio_ports nio_ports_assertions #(.H_DIR(H_DIR)) nio_ports_assertions_inst (.aclk, .aresetn,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .standby_q, .port_h_in,
	.port_a_out, .port_a_oe_n, .port_b_oe_n, .port_h_oe_n, .port_l_out, .port_l_oe_n);

// [nio_ports_tb_top.sv]
// bench for nio_ports: axi4-lite master, random pin levels, edge flag and wake
// assumes nio_pins_model on the pins and the checker bound from its own file
`timescale 1ns/1ps
`include "nio_map.vh"
module nio_ports_tb_top;
	reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	reg s_axi_bready = 1, s_axi_rready = 1;
	reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg [34:0] ext = 0;
	reg [63:0] rnd;
	reg [1:0] rsp_q;
	integer seed = 40, miscompares = 0, check_count = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, standby_q;
	wire [1:0] s_axi_bresp, s_axi_rresp, port_c_in, port_g_in, port_h_in, port_j_in;
	wire [1:0] port_k_in, port_l_in, port_l_out;
	wire [31:0] s_axi_rdata;
	wire [3:0] port_a_in, port_b_in, port_d_in, port_e_in, port_i_in;
	wire [3:0] port_a_out, port_a_oe_n, port_b_out, port_b_oe_n;
	wire [2:0] port_f_in;
	localparam [34:0] H_M = 35'h1800000;
	always #12.5 aclk = ~aclk;
	nio_ports nio_ports_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_q, .port_a_in, .port_b_in,
		.port_c_in, .port_d_in, .port_e_in, .port_f_in, .port_g_in, .port_h_in, .port_i_in,
		.port_j_in, .port_k_in, .port_l_in, .port_a_out, .port_a_oe_n, .port_b_out,
		.port_b_oe_n, .port_c_out(), .port_c_oe_n(), .port_d_out(), .port_d_oe_n(),
		.port_e_out(), .port_e_oe_n(), .port_f_out(), .port_f_oe_n(), .port_g_out(),
		.port_g_oe_n(), .port_h_out(), .port_h_oe_n(), .port_l_out, .port_l_oe_n());
	nio_pins_model nio_pins_model_inst (.ext, .port_a_out, .port_a_oe_n, .port_b_out,
		.port_b_oe_n, .port_a_in, .port_b_in, .port_c_in, .port_d_in, .port_e_in, .port_f_in,
		.port_g_in, .port_h_in, .port_i_in, .port_j_in, .port_k_in, .port_l_in);
	function [3:0] pin_exp(input [7:0] a);
		case (a)
			`NIO_OFS_PORT_A: pin_exp = ext[3:0];
			`NIO_OFS_PORT_B: pin_exp = ext[7:4];
			`NIO_OFS_PORT_C: pin_exp = {2'b0, ext[9:8]};
			`NIO_OFS_PORT_D: pin_exp = ext[13:10];
			`NIO_OFS_PORT_E: pin_exp = ext[17:14];
			`NIO_OFS_PORT_F: pin_exp = {1'b0, ext[20:18]};
			`NIO_OFS_PORT_G: pin_exp = {2'b0, ext[22:21]};
			`NIO_OFS_PORT_I: pin_exp = ext[28:25];
			`NIO_OFS_PORT_J: pin_exp = {2'b0, ext[30:29]};
			default: pin_exp = {2'b0, ext[32:31]};
		endcase
	endfunction
	task final_report;
		begin
			$display("checks %0d mismatches %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task check(input string nm, input [31:0] e, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("BAD %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// bready stays high, so the response is taken at the edge it is seen
	task wr(input [7:0] a, input [31:0] d);
		reg aw, w;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			aw = 1;
			w = 1;
			while (aw || w) begin
				@(posedge aclk);
				if (aw && s_axi_awready === 1'b1) begin
					s_axi_awvalid <= 0;
					aw = 0;
				end
				if (w && s_axi_wready === 1'b1) begin
					s_axi_wvalid <= 0;
					w = 0;
				end
			end
			while (s_axi_bvalid !== 1'b1) @(posedge aclk);
			rsp_q = s_axi_bresp;
		end
	endtask
	task rd(input string nm, input [7:0] a, input [31:0] e);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1;
			@(posedge aclk);
			while (s_axi_arready !== 1'b1) @(posedge aclk);
			s_axi_arvalid <= 0;
			@(posedge aclk);
			while (s_axi_rvalid !== 1'b1) @(posedge aclk);
			rsp_q = s_axi_rresp;
			check(nm, e, s_axi_rdata);
		end
	endtask
	task rdp(input string nm, input [7:0] a);
		rd(nm, a, {28'h0, pin_exp(a)});
	endtask
	initial begin
		#500000;
		miscompares = miscompares + 1;
		final_report;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd("ab_dir", `NIO_OFS_AB_DIR, 32'h0);
		repeat (6) begin
			rnd = {$random(seed), $random(seed)};
			ext <= (rnd[34:0] & ~H_M) | (ext & H_M);
			wr(`NIO_OFS_PORT_A, rnd[63:32]);
			repeat (8) @(posedge aclk);
			rdp("port_i", `NIO_OFS_PORT_I);
			rdp("port_j", `NIO_OFS_PORT_J);
			rdp("port_k", `NIO_OFS_PORT_K);
			rdp("port_b", `NIO_OFS_PORT_B);
			rdp("port_a", `NIO_OFS_PORT_A);
			rdp("port_c", `NIO_OFS_PORT_C);
			rdp("port_d", `NIO_OFS_PORT_D);
			rdp("port_e", `NIO_OFS_PORT_E);
			rdp("port_f", `NIO_OFS_PORT_F);
			rdp("port_g", `NIO_OFS_PORT_G);
		end
		wr(`NIO_OFS_PORT_A, 32'h5);
		wr(`NIO_OFS_PORT_B, 32'ha);
		wr(`NIO_OFS_AB_DIR, 32'h3);
		check("bresp", {30'h0, `NIO_RESP_OKAY}, {30'h0, rsp_q});
		rd("port_a", `NIO_OFS_PORT_A, 32'h5);
		rd("port_b", `NIO_OFS_PORT_B, 32'ha);
		rd("ab_dir", `NIO_OFS_AB_DIR, 32'h3);
		check("port_b_pins", 32'h0a, {24'h0, port_b_oe_n, port_b_out});
		wr(`NIO_OFS_AB_DIR, 32'h0);
		repeat (8) @(posedge aclk);
		rdp("port_a", `NIO_OFS_PORT_A);
		wr(`NIO_OFS_PORT_L, 32'h1);
		rd("port_l", `NIO_OFS_PORT_L, {30'h0, ext[34], 1'b1});
		check("port_l_out", 32'h1, {30'h0, port_l_out});
		wr(`NIO_OFS_PORT_L, 32'h0);
		rd("port_l", `NIO_OFS_PORT_L, {30'h0, ext[34], 1'b0});
		check("port_l_out", 32'h0, {30'h0, port_l_out});
		rd("unmapped", 8'h3c, 32'h0);
		check("rresp", {30'h0, `NIO_RESP_SLVERR}, {30'h0, rsp_q});
		wr(8'h3c, 32'h1);
		check("bresp", {30'h0, `NIO_RESP_SLVERR}, {30'h0, rsp_q});
		ext[24] <= 1'b1;
		repeat (8) @(posedge aclk);
		rd("port_h", `NIO_OFS_PORT_H, 32'h6);
		wr(`NIO_OFS_PORT_H, 32'h0);
		rd("port_h", `NIO_OFS_PORT_H, 32'h2);
		wr(`NIO_OFS_STANDBY, 32'h1);
		ext[24] <= 1'b0;
		repeat (8) @(posedge aclk);
		ext[24] <= 1'b1;
		repeat (8) @(posedge aclk);
		check("standby", 32'h1, {31'h0, standby_q});
		ext[23] <= 1'b1;
		repeat (8) @(posedge aclk);
		check("standby", 32'h0, {31'h0, standby_q});
		rd("port_h", `NIO_OFS_PORT_H, 32'h7);
		final_report;
	end
endmodule // nio_ports_tb_top
